// ---- rtl/lcdc_pkg.sv ----
// lcdc_pkg: register map, field layout, reset values and drive constants
// assumes a 32-bit apb master; register indices are word numbers (byte x4)
package lcdc_pkg;

  // register indices; byte address is four times the index
  localparam logic [29:0] IDX_DISPLAY_MODE_CONTROL = 30'h000050a0;
  localparam logic [29:0] IDX_CONTRAST_ADJUST      = 30'h000050a1;
  localparam logic [29:0] IDX_DUTY_CLOCK_CONTROL   = 30'h000050a2;
  localparam logic [29:0] IDX_VOLTAGE_REGULATOR    = 30'h000050a3;
  localparam logic [29:0] IDX_BOOSTER_POWER        = 30'h000050a4;
  localparam logic [29:0] IDX_FRAME_IRQ_MASK       = 30'h000050a5;
  localparam logic [29:0] IDX_FRAME_IRQ_FLAG       = 30'h000050a6;

  // field positions
  localparam int NEG_DISP_BIT   = 4;
  localparam int MODE_LSB       = 0;
  localparam int CONTRAST_LSB   = 0;
  localparam int DUTY_LSB       = 0;
  localparam int HEAVY_LOAD_BIT = 4;
  localparam int REG_SRC_BIT    = 1;
  localparam int BOOSTER_BIT    = 0;
  localparam int IRQ_EN_BIT     = 0;
  localparam int IRQ_FLAG_BIT   = 0;

  // reset values
  localparam logic       NEG_DISP_RST   = 1'b1;
  localparam logic [1:0] MODE_RST       = 2'h0;
  localparam logic [3:0] CONTRAST_RST   = 4'h0;
  localparam logic [1:0] DUTY_RST       = 2'h2;

  typedef enum logic [1:0] {
    LCDC_MODE_OFF     = 2'b00,
    LCDC_MODE_NORMAL  = 2'b01,
    LCDC_MODE_ALL_ON  = 2'b10,
    LCDC_MODE_ALL_OFF = 2'b11
  } lcdc_mode_t;

  localparam logic [1:0] DUTY_16 = 2'h1;
  localparam logic [1:0] DUTY_32 = 2'h2;

  // panel geometry
  localparam int NUM_COM    = 32;
  localparam int NUM_SEG    = 72;
  localparam int SEG_AT_32  = 56;
  localparam logic [4:0] LAST_COM_16 = 5'h0f;
  localparam logic [4:0] LAST_COM_32 = 5'h1f;

  // one common line period in clock cycles (plain default)
  localparam int LINE_CYCLES = 64;

endpackage : lcdc_pkg

// ---- rtl/lcdc_frame_gen.sv ----
// lcdc_frame_gen: common scan counter and frame signal
// assumes run_i and duty inputs come from registers on the same clock
`timescale 1ns/10ps
module lcdc_frame_gen
  import lcdc_pkg::*;
#(
  parameter int LINE_LEN = LINE_CYCLES
) (
  input  wire logic       clk_i,      // system clock
  input  wire logic       rst_n_i,    // async reset, active low
  input  wire logic       run_i,      // scan enabled
  input  wire logic       duty16_i,   // 1/16 duty selected
  output logic [4:0]      com_idx_o,  // current common line
  output logic            frame_o     // frame signal, high on line 0
);

  logic [15:0] line_cnt_q;
  logic [4:0]  com_q;
  logic        frame_q;
  logic        line_end;
  logic [4:0]  last_com;

  assign line_end = (line_cnt_q == 16'(LINE_LEN - 1));
  assign last_com = duty16_i ? LAST_COM_16 : LAST_COM_32;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_cnt_q <= 16'h0000;
    end else if (!run_i || line_end) begin
      line_cnt_q <= 16'h0000;
    end else begin
      line_cnt_q <= line_cnt_q + 16'h0001;
    end
  end

  // a change to 1/16 duty past line 15 wraps at the next line end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      com_q <= 5'h00;
    end else if (!run_i) begin
      com_q <= 5'h00;
    end else if (line_end) begin
      com_q <= (com_q >= last_com) ? 5'h00 : com_q + 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= run_i && (com_q == 5'h00);
    end
  end

  assign com_idx_o = com_q;
  assign frame_o   = frame_q;

endmodule // lcdc_frame_gen

// ---- rtl/lcdc_drive.sv ----
// lcdc_drive: common and segment drive from mode, inversion and row data
// assumes row_i is the display memory row for com_idx_i, read only
`timescale 1ns/10ps
module lcdc_drive
  import lcdc_pkg::*;
(
  input  wire logic               clk_i,      // system clock
  input  wire logic               rst_n_i,    // async reset, active low
  input  wire logic [1:0]         mode_i,     // display mode
  input  wire logic               neg_i,      // negative_display bit
  input  wire logic               duty16_i,   // 1/16 duty selected
  input  wire logic [4:0]         com_idx_i,  // scanned common
  input  wire logic [NUM_SEG-1:0] row_i,      // memory row for that common
  output logic [NUM_COM-1:0]      com_o,      // common select, one-hot or zero
  output logic                    static_o,   // commons in static waveform
  output logic [NUM_SEG-1:0]      seg_o       // segment on levels
);

  logic [NUM_SEG-1:0] seg_mask;
  logic [NUM_SEG-1:0] pix;
  logic [NUM_COM-1:0] com_sel;

  assign seg_mask = duty16_i ? {NUM_SEG{1'b1}}
                             : {{(NUM_SEG-SEG_AT_32){1'b0}}, {SEG_AT_32{1'b1}}};
  // inversion on the drive path only, memory is never written
  assign pix     = neg_i ? row_i : ~row_i;
  assign com_sel = NUM_COM'(1) << com_idx_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      com_o    <= '0;
      static_o <= 1'b0;
      seg_o    <= '0;
    end else begin
      unique case (lcdc_mode_t'(mode_i))
        LCDC_MODE_OFF: begin
          com_o    <= '0;
          static_o <= 1'b0;
          seg_o    <= '0;
        end
        LCDC_MODE_NORMAL: begin
          com_o    <= com_sel;
          static_o <= 1'b0;
          seg_o    <= pix & seg_mask;
        end
        LCDC_MODE_ALL_ON: begin  // dynamic commons, forced on
          com_o    <= com_sel;
          static_o <= 1'b0;
          seg_o    <= seg_mask;
        end
        LCDC_MODE_ALL_OFF: begin  // static commons, forced off
          com_o    <= '0;
          static_o <= 1'b1;
          seg_o    <= '0;
        end
      endcase
    end
  end

endmodule // lcdc_drive

// ---- rtl/lcdc_regs.sv ----
// lcdc_regs: apb register bank and panel drive of the dot-matrix lcd driver
// assumes a 32-bit apb master on CLOCK_I; row data read from display memory
`timescale 1ns/10ps
module lcdc_regs
  import lcdc_pkg::*;
#(
  parameter int LINE_LEN = LINE_CYCLES
) (
  input  wire logic               CLOCK_I,      // 200 MHz system clock
  input  wire logic               RESETN_I,     // async reset, active low
  input  wire logic               PSEL_I,       // apb select
  input  wire logic               PENABLE_I,    // apb access phase
  input  wire logic               PWRITE_I,     // apb write
  input  wire logic [31:0]        PADDR_I,      // apb byte address
  input  wire logic [31:0]        PWDATA_I,     // apb write data
  output logic [31:0]             PRDATA_O,     // apb read data
  output logic                    PREADY_O,     // apb ready
  output logic                    PSLVERR_O,    // apb error, unmapped
  input  wire logic [NUM_SEG-1:0] ROW_DATA_I,   // memory row for COM_IDX_O
  output logic [4:0]              COM_IDX_O,    // common being scanned
  output logic [NUM_COM-1:0]      COM_O,        // common drive select
  output logic                    COM_STATIC_O, // commons static waveform
  output logic [NUM_SEG-1:0]      SEG_O,        // segment drive
  output logic                    BIAS_EN_O,    // regulator bias supply on
  output logic [3:0]              CONTRAST_O,   // bias voltage scale
  output logic                    DUTY16_O,     // 1/16 duty in use
  output logic                    HEAVY_LOAD_O, // heavy-load protection
  output logic                    REG_SRC_O,    // 1 boosted rail, 0 main
  output logic                    BOOSTER_ON_O, // supply booster on
  output logic                    FRAME_O,      // internal frame signal
  output logic                    IRQ_O         // to interrupt controller
);

  logic       neg_q;
  logic [1:0] mode_q;
  logic [3:0] contrast_q;
  logic [1:0] duty_q;
  logic       heavy_q;
  logic       src_q;
  logic       boost_q;
  logic       irq_en_q;
  logic       flag_q;
  logic       flag_d;
  logic       frame_prev_q;
  logic       frame;
  logic       frame_rise;
  logic       wr;
  logic       rd;
  logic [29:0] idx;
  logic [7:0] rdata;
  logic       hit;
  logic [31:0] prdata_q;
  logic       duty16;

  assign idx = PADDR_I[31:2];
  assign wr  = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd  = PSEL_I && PENABLE_I && !PWRITE_I;

  function automatic logic is_reg(input logic [29:0] a, input logic [29:0] r);
    return a == r;
  endfunction

  assign hit = (idx >= IDX_DISPLAY_MODE_CONTROL)
            && (idx <= IDX_FRAME_IRQ_FLAG);

  // zero wait states; unmapped words answer with an error
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;

  // display control: only the mode and inversion bits hold state
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      neg_q  <= NEG_DISP_RST;
      mode_q <= MODE_RST;
    end else if (wr && is_reg(idx, IDX_DISPLAY_MODE_CONTROL)) begin
      neg_q  <= PWDATA_I[NEG_DISP_BIT];
      mode_q <= PWDATA_I[MODE_LSB+:2];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      contrast_q <= CONTRAST_RST;
    end else if (wr && is_reg(idx, IDX_CONTRAST_ADJUST)) begin
      contrast_q <= PWDATA_I[CONTRAST_LSB+:4];
    end
  end

  // reserved duty codes are stored as written and drive as 1/32
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      duty_q <= DUTY_RST;
    end else if (wr && is_reg(idx, IDX_DUTY_CLOCK_CONTROL)) begin
      duty_q <= PWDATA_I[DUTY_LSB+:2];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      heavy_q <= 1'b0;
    end else if (wr && is_reg(idx, IDX_VOLTAGE_REGULATOR)) begin
      heavy_q <= PWDATA_I[HEAVY_LOAD_BIT];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      src_q   <= 1'b0;
      boost_q <= 1'b0;
    end else if (wr && is_reg(idx, IDX_BOOSTER_POWER)) begin
      src_q   <= PWDATA_I[REG_SRC_BIT];
      boost_q <= PWDATA_I[BOOSTER_BIT];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_en_q <= 1'b0;
    end else if (wr && is_reg(idx, IDX_FRAME_IRQ_MASK)) begin
      irq_en_q <= PWDATA_I[IRQ_EN_BIT];
    end
  end

  // a frame edge in the clearing cycle is kept: set beats clear
  assign frame_rise = frame && !frame_prev_q;
  always_comb begin
    flag_d = flag_q;
    if (wr && is_reg(idx, IDX_FRAME_IRQ_FLAG) && PWDATA_I[IRQ_FLAG_BIT]) begin
      flag_d = 1'b0;
    end
    if (frame_rise) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flag_q       <= 1'b0;
      frame_prev_q <= 1'b0;
    end else begin
      flag_q       <= flag_d;
      frame_prev_q <= frame;
    end
  end

  // read mux; reserved positions are zero
  always_comb begin
    rdata = 8'h00;
    unique case (idx)
      IDX_DISPLAY_MODE_CONTROL: begin
        rdata[NEG_DISP_BIT]  = neg_q;
        rdata[MODE_LSB+:2]   = mode_q;
      end
      IDX_CONTRAST_ADJUST:    rdata[CONTRAST_LSB+:4] = contrast_q;
      IDX_DUTY_CLOCK_CONTROL: rdata[DUTY_LSB+:2] = duty_q;
      IDX_VOLTAGE_REGULATOR:  rdata[HEAVY_LOAD_BIT] = heavy_q;
      IDX_BOOSTER_POWER: begin
        rdata[REG_SRC_BIT] = src_q;
        rdata[BOOSTER_BIT] = boost_q;
      end
      IDX_FRAME_IRQ_MASK:     rdata[IRQ_EN_BIT] = irq_en_q;
      IDX_FRAME_IRQ_FLAG:     rdata[IRQ_FLAG_BIT] = flag_q;
      default:                rdata = 8'h00;
    endcase
  end

  // read data held in a flop, loaded in the setup cycle of a read
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prdata_q <= 32'h00000000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      prdata_q <= {24'h000000, rdata};
    end
  end
  assign PRDATA_O = prdata_q;

  assign duty16 = (duty_q == DUTY_16);

  lcdc_frame_gen #(
    .LINE_LEN (LINE_LEN)
  ) u_frame (
    .clk_i     (CLOCK_I),
    .rst_n_i   (RESETN_I),
    .run_i     (mode_q != LCDC_MODE_OFF),
    .duty16_i  (duty16),
    .com_idx_o (COM_IDX_O),
    .frame_o   (frame)
  );

  lcdc_drive u_drive (
    .clk_i     (CLOCK_I),
    .rst_n_i   (RESETN_I),
    .mode_i    (mode_q),
    .neg_i     (neg_q),
    .duty16_i  (duty16),
    .com_idx_i (COM_IDX_O),
    .row_i     (ROW_DATA_I),
    .com_o     (COM_O),
    .static_o  (COM_STATIC_O),
    .seg_o     (SEG_O)
  );

  // display off cuts the regulator supply, bias pins fall to ground
  assign BIAS_EN_O    = (mode_q != LCDC_MODE_OFF);
  assign CONTRAST_O   = contrast_q;
  assign DUTY16_O     = duty16;
  assign HEAVY_LOAD_O = heavy_q;
  assign REG_SRC_O    = src_q;
  assign BOOSTER_ON_O = boost_q;
  assign FRAME_O      = frame;
  assign IRQ_O        = flag_q && irq_en_q;

endmodule // lcdc_regs

// ---- tb/lcdc_panel_model.sv ----
// lcdc_panel_model: display memory image as the common scan reads it
// assumes the driver presents the scanned common; row answers at once
`timescale 1ns/10ps
module lcdc_panel_model
  import lcdc_pkg::*;
(
  input  wire logic [4:0]    com_idx_i, // scanned common
  output logic [NUM_SEG-1:0] row_o      // stored row for that common
);
  // read-only image: no path here can alter it
  assign row_o = {9{3'b011, com_idx_i}};
endmodule // lcdc_panel_model

// ---- tb/lcdc_regs_checker.sv ----
// lcdc_regs_checker: port-level properties of the lcd register bank
// assumes bind to lcdc_regs; one clock, async active-low reset
`timescale 1ns/10ps
module lcdc_regs_checker
  import lcdc_pkg::*;
#(
  parameter int LINE_LEN = LINE_CYCLES
) (
  input wire logic               CLOCK_I,      // clock
  input wire logic               RESETN_I,     // reset
  input wire logic               PSEL_I,       // select
  input wire logic               PENABLE_I,    // access
  input wire logic               PWRITE_I,     // write
  input wire logic [31:0]        PADDR_I,      // address
  input wire logic [31:0]        PWDATA_I,     // write data
  input wire logic [4:0]         COM_IDX_O,    // scanned common
  input wire logic [NUM_COM-1:0] COM_O,        // commons
  input wire logic               COM_STATIC_O, // static commons
  input wire logic               BIAS_EN_O,    // bias supply
  input wire logic [3:0]         CONTRAST_O,   // contrast
  input wire logic               HEAVY_LOAD_O, // heavy load
  input wire logic               REG_SRC_O,    // source select
  input wire logic               BOOSTER_ON_O, // booster
  input wire logic               FRAME_O,      // frame
  input wire logic               IRQ_O         // request
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_wr(logic [29:0] idx);
    PSEL_I && PENABLE_I && PWRITE_I && PADDR_I[31:2] == idx;
  endsequence
  // registered drive lags the mode by a cycle, hence two cycles of cause
  property p_off; !BIAS_EN_O [*2] |-> COM_O == '0; endproperty
  a_off: assert property (p_off) else $error("commons driven in off");
  property p_static; COM_STATIC_O [*2] |-> COM_O == '0; endproperty
  a_static: assert property (p_static) else $error("static with scan");
  property p_onehot; $onehot0(COM_O); endproperty
  a_onehot: assert property (p_onehot) else $error("commons not one-hot");
  property p_frame; $rose(FRAME_O) |-> COM_IDX_O == 5'h00; endproperty
  a_frame: assert property (p_frame) else $error("frame off line 0");
  property p_contrast;
    s_wr(IDX_CONTRAST_ADJUST) |=> CONTRAST_O == $past(PWDATA_I[3:0]);
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast");
  property p_heavy;
    s_wr(IDX_VOLTAGE_REGULATOR) |=> HEAVY_LOAD_O == $past(PWDATA_I[4]);
  endproperty
  a_heavy: assert property (p_heavy) else $error("heavy load");
  property p_boost;
    s_wr(IDX_BOOSTER_POWER) |=>
      {REG_SRC_O, BOOSTER_ON_O} == $past(PWDATA_I[1:0]);
  endproperty
  a_boost: assert property (p_boost) else $error("booster");
  property p_mask; s_wr(IDX_FRAME_IRQ_MASK) ##0 !PWDATA_I[0] |=> !IRQ_O;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_clear;
    s_wr(IDX_FRAME_IRQ_FLAG) ##0 (PWDATA_I[0] && !$rose(FRAME_O)) |=> !IRQ_O;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule // lcdc_regs_checker

// ---- tb/test_lcdc_regs.sv ----
// test_lcdc_regs: apb-driven test of the lcd register bank and drive
// assumes lcdc_pkg compiled first; short line length keeps frames brief
`timescale 1ns/10ps
module test_lcdc_regs
  import lcdc_pkg::*;
;
  localparam int LINE_LEN = 4;
  localparam logic [71:0] M56 = {16'h0000, {56{1'b1}}};
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic com_static, bias_en, duty16, heavy, reg_src, boost_on, frame, irq;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [71:0] row, seg;
  logic [31:0] com;
  logic [4:0] com_idx, mx;
  logic [3:0] contrast;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  logic [29:0] idx[7] = '{IDX_DISPLAY_MODE_CONTROL, IDX_CONTRAST_ADJUST,
    IDX_DUTY_CLOCK_CONTROL, IDX_VOLTAGE_REGULATOR, IDX_BOOSTER_POWER,
    IDX_FRAME_IRQ_MASK, IDX_FRAME_IRQ_FLAG};
  logic [7:0] rstv[7] = '{8'h10, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk[6] = '{8'h13, 8'h0f, 8'h03, 8'h10, 8'h03, 8'h01};

  lcdc_regs #(.LINE_LEN(LINE_LEN)) lcdc_regs_inst (.CLOCK_I(clk),
    .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .ROW_DATA_I(row), .COM_IDX_O(com_idx), .COM_O(com),
    .COM_STATIC_O(com_static), .SEG_O(seg), .BIAS_EN_O(bias_en),
    .CONTRAST_O(contrast), .DUTY16_O(duty16), .HEAVY_LOAD_O(heavy),
    .REG_SRC_O(reg_src), .BOOSTER_ON_O(boost_on), .FRAME_O(frame),
    .IRQ_O(irq));
  lcdc_panel_model lcdc_panel_model_inst (.com_idx_i(com_idx), .row_o(row));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a run past 20000 cycles lands here; handshake and frame waits time out on their own
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("[ERR] %0t run timed out", $time);
      conclude();
    end
  end

  task automatic chk(input logic [71:0] s, input logic [71:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic [29:0] i, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t bus handshake timed out", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask

  task automatic wframe;
    int n;
    n = 0;
    while (frame !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    while (frame !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) begin
      n_mismatch++;
      $display("[ERR] %0t frame wait timed out", $time);
    end
    @(negedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(bias_en, 1'b0);
    for (int k = 0; k < 7; k++) begin
      apb(idx[k], 1'b0, 8'h00);
      chk(rd, rstv[k]);
    end
    // reserved positions are always written as zero by software
    for (int k = 0; k < 6; k++) begin
      apb(idx[k], 1'b1, msk[k]);
      apb(idx[k], 1'b0, 8'h00);
      chk(rd, msk[k]);
      apb(idx[k], 1'b1, 8'h00);
      apb(idx[k], 1'b0, 8'h00);
      chk(rd, 0);
    end
    apb(30'h000050a7, 1'b0, 8'h00);
    chk({err, rd}, {1'b1, 32'h0});
    for (int d = 1; d < 3; d++) begin
      apb(IDX_DUTY_CLOCK_CONTROL, 1'b1, 8'(d));
      chk(duty16, d == 1);
      // the bench clock runs from time zero, so the scan clock is present
      apb(IDX_DISPLAY_MODE_CONTROL, 1'b1, 8'h11);
      wframe();
      mx = 5'h00;
      repeat (140) begin
        @(negedge clk);
        if (com_idx > mx) mx = com_idx;
      end
      chk(mx, (d == 1) ? 5'h0f : 5'h1f);
      apb(IDX_DISPLAY_MODE_CONTROL, 1'b1, 8'h00);
      repeat (2) @(negedge clk);
      chk({bias_en, com}, 33'h0);
    end
    // second normal pass shows the stored image came back intact
    for (int v = 0; v < 3; v++) begin
      apb(IDX_DISPLAY_MODE_CONTROL, 1'b1, (v == 1) ? 8'h01 : 8'h11);
      wframe();
      chk(seg, ((v == 1) ? ~{9{8'h60}} : {9{8'h60}}) & M56);
    end
    apb(IDX_DISPLAY_MODE_CONTROL, 1'b1, 8'h12);
    repeat (6) @(negedge clk);
    chk({seg, |com, com_static}, {M56, 2'b10});
    apb(IDX_DISPLAY_MODE_CONTROL, 1'b1, 8'h13);
    repeat (3) @(negedge clk);
    chk({com_static, com}, {1'b1, 32'h0});
    apb(IDX_DISPLAY_MODE_CONTROL, 1'b1, 8'h11);
    apb(IDX_FRAME_IRQ_FLAG, 1'b1, 8'h01);
    wframe();
    apb(IDX_FRAME_IRQ_FLAG, 1'b0, 8'h00);
    chk({rd, irq}, {32'h1, 1'b0});
    apb(IDX_FRAME_IRQ_MASK, 1'b1, 8'h01);
    chk(irq, 1'b1);
    apb(IDX_FRAME_IRQ_FLAG, 1'b1, 8'h00);
    chk(irq, 1'b1);
    apb(IDX_FRAME_IRQ_FLAG, 1'b1, 8'h01);
    chk(irq, 1'b0);
    // display is switched off before any sleep would follow
    apb(IDX_DISPLAY_MODE_CONTROL, 1'b1, 8'h10);
    chk(bias_en, 1'b0);
    conclude();
  end
endmodule // test_lcdc_regs

bind lcdc_regs lcdc_regs_checker #(.LINE_LEN(LINE_LEN)) lcdc_regs_checker_inst (
  .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .COM_IDX_O(COM_IDX_O), .COM_O(COM_O),
  .COM_STATIC_O(COM_STATIC_O), .BIAS_EN_O(BIAS_EN_O),
  .CONTRAST_O(CONTRAST_O), .HEAVY_LOAD_O(HEAVY_LOAD_O),
  .REG_SRC_O(REG_SRC_O), .BOOSTER_ON_O(BOOSTER_ON_O), .FRAME_O(FRAME_O),
  .IRQ_O(IRQ_O));
